// [verilog/lcep_top.sv]
// Line-cycle apparent energy accumulation and calibration pulse outputs.
// Assumes register strobes, zero crossings and energy quanta come from
// logic on mclk; upstream chains apply gain, offset and no-load.
//
// Function
// - Line-cycle bit per channel syncs apparent accumulation; off at reset.
// - One half-cycle count register sets the period for both channels.
// - Periods up to 65,535 half line cycles are supported.
// - Period end updates the result of each line-cycle channel and sets the done flag.
// - Done flag with its enable drives the active-low interrupt pin.
// - Next period starts at once while line-cycle enables stay set.
// - Results hold between period ends, then are overwritten.
// - Clear-on-read zeroes a result until the period ends.
// - A count written mid-period applies from the next period.
// - Ampere-hour mode accumulates rms current instead of apparent power.
// - Ampere-hour mode makes apparent pulse sources follow rms current.
// - Apparent-path calibration and no-load apply to rms accumulation.
// - Each converter gives one pulse per energy LSB.
// - An output pulse comes after divider-count converter pulses.
// - Each output source is selectable from the listed quantities.
// - Summed active source runs at half the channel sum.
// - Both outputs disabled at reset; enabled while disable bit clear.
// - Periods over 160 ms give fixed 80 ms pulses.
// - Periods of 160 ms or less give 50% duty.
// - Pulse outputs are active low.
// - Divider zero passes converter rate undivided.
// - Bit 6 of mode register enables clear-on-read; set by default.
// - Energy results wrap at the 24-bit signed limits.
`include "lcep_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lcep_top #(
   parameter int unsigned CLK_HZ = `LCEP_CLK_HZ,
   parameter int unsigned PULSE_LOW_CYC =
      `LCEP_PULSE_LOW_MS * (`LCEP_CLK_HZ / 1000),
   parameter int unsigned PULSE_LIM_CYC =
      `LCEP_PULSE_LIM_MS * (`LCEP_CLK_HZ / 1000)
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register access port
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   // Measurement inputs
   input wire logic zx_stb,
   input wire logic [7:0] q_stb,
   input wire logic [7:0] q_neg,
   input wire logic amp_hour_en,
   // Pins
   output logic irq_n,
   output logic pulse_out_one_n,
   output logic pulse_out_two_n
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] mode_q;
   logic [15:0] hcyc_q;
   logic [15:0] div_one_q;
   logic [15:0] div_two_q;
   logic [15:0] cfg_q;
   logic irq_en_q;
   logic done_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   lcep_pkg::lcep_period_t period_q;
   logic [15:0] len_q;
   logic [15:0] hc_cnt_q;
   logic line_any;
   logic count_hit;
   logic period_end;
   logic clr_a;
   logic clr_b;
   logic st_read;
   logic app_stb_a;
   logic app_stb_b;
   logic app_neg_a;
   logic app_neg_b;
   logic [23:0] energy_a;
   logic [23:0] energy_b;
   lcep_pkg::lcep_src_t sel_one;
   lcep_pkg::lcep_src_t sel_two;
   logic half_one_q;
   logic half_two_q;
   logic [1:0] sum_one;
   logic [1:0] sum_two;
   logic [1:0] inc_one;
   logic [1:0] inc_two;

   // ****************************************
   // Functions
   // ****************************************

   // Converter pulses this cycle for any source except the half-sum source
   function automatic logic [1:0] src_count(
      input lcep_pkg::lcep_src_t sel,
      input logic [7:0] stb,
      input logic amp
   );
      logic [1:0] n;
      n = 2'b00;
      case (sel)
         `LCEP_SRC_ACT_A: n = {1'b0, stb[`LCEP_Q_ACT]};
         `LCEP_SRC_ACT_B: n = {1'b0, stb[`LCEP_Q_ACT + 1]};
         `LCEP_SRC_REACT_A: n = {1'b0, stb[`LCEP_Q_REACT]};
         `LCEP_SRC_REACT_B: n = {1'b0, stb[`LCEP_Q_REACT + 1]};
         `LCEP_SRC_APP_A: begin
            n = {1'b0, amp ? stb[`LCEP_Q_CURRENT_RMS_VALUE] : stb[`LCEP_Q_APP]};
         end
         `LCEP_SRC_APP_B: begin
            n = {1'b0, amp ? stb[`LCEP_Q_CURRENT_RMS_VALUE + 1]
                           : stb[`LCEP_Q_APP + 1]};
         end
         `LCEP_SRC_CURRENT_RMS_VALUE_A: n = {1'b0, stb[`LCEP_Q_CURRENT_RMS_VALUE]};
         `LCEP_SRC_CURRENT_RMS_VALUE_B: n = {1'b0, stb[`LCEP_Q_CURRENT_RMS_VALUE + 1]};
         `LCEP_SRC_CURRENT_RMS_VALUE_SUM: begin
            n = {1'b0, stb[`LCEP_Q_CURRENT_RMS_VALUE]} + {1'b0, stb[`LCEP_Q_CURRENT_RMS_VALUE + 1]};
         end
         default: n = 2'b00;
      endcase
      return n;
   endfunction : src_count

   // Residue plus both active quanta, for the half-sum source
   function automatic logic [1:0] half_total(
      input logic res,
      input logic [7:0] stb
   );
      return {1'b0, res} + {1'b0, stb[`LCEP_Q_ACT]}
         + {1'b0, stb[`LCEP_Q_ACT + 1]};
   endfunction : half_total

   // ****************************************
   // Register writes
   // ****************************************

   // Software-owned configuration registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= `LCEP_MODE_RST;
         hcyc_q <= `LCEP_HCYC_RST;
         div_one_q <= `LCEP_DIV_RST;
         div_two_q <= `LCEP_DIV_RST;
         cfg_q <= `LCEP_CFG_RST;
         irq_en_q <= 1'b0;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `LCEP_ADR_MODE: mode_q <= reg_wdata[7:0];
            `LCEP_ADR_HCYC: hcyc_q <= reg_wdata[15:0];
            `LCEP_ADR_DIV1: div_one_q <= reg_wdata[15:0];
            `LCEP_ADR_DIV2: div_two_q <= reg_wdata[15:0];
            `LCEP_ADR_CFG: cfg_q <= reg_wdata[15:0];
            `LCEP_ADR_IRQEN: irq_en_q <= reg_wdata[`LCEP_IRQ_DONE];
            default: irq_en_q <= irq_en_q;
         endcase
      end
   end

   // ****************************************
   // Line-cycle period engine
   // ****************************************

   // Either channel in line-cycle mode runs the shared engine
   assign line_any = mode_q[`LCEP_MODE_LA] | mode_q[`LCEP_MODE_LB];

   // Crossing that completes the latched count; zero ends each crossing
   assign count_hit = ({1'b0, hc_cnt_q} + 17'h00001) >= {1'b0, len_q};
   assign period_end = (period_q == lcep_pkg::LCEP_RUN) && line_any
      && zx_stb && count_hit;

   // Count half cycles; latch the length only at a period boundary
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         period_q <= lcep_pkg::LCEP_IDLE;
         len_q <= `LCEP_HCYC_RST;
         hc_cnt_q <= 16'h0000;
      end else if (clk_en) begin
         case (period_q)
            lcep_pkg::LCEP_IDLE: begin
               // First period starts unaligned to a crossing
               if (line_any) begin
                  period_q <= lcep_pkg::LCEP_RUN;
                  len_q <= hcyc_q;
                  hc_cnt_q <= 16'h0000;
               end
            end
            lcep_pkg::LCEP_RUN: begin
               if (!line_any) begin
                  period_q <= lcep_pkg::LCEP_IDLE;
                  hc_cnt_q <= 16'h0000;
               end else if (period_end) begin
                  len_q <= hcyc_q;
                  hc_cnt_q <= 16'h0000;
               end else if (zx_stb) begin
                  hc_cnt_q <= hc_cnt_q + 16'h0001;
               end
            end
            default: period_q <= lcep_pkg::LCEP_IDLE;
         endcase
      end
   end

   // ****************************************
   // Done flag and interrupt pin
   // ****************************************

   // Reading the status register clears the flag; a new end wins
   assign st_read = reg_rd && (reg_addr == `LCEP_ADR_IRQST);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (clk_en) begin
         done_q <= period_end || (done_q && !st_read);
      end
   end

   // Active-low interrupt while flag and enable are both set
   assign irq_n = ~(done_q & irq_en_q);

   // ****************************************
   // Apparent energy accumulation
   // ****************************************

   // Ampere-hour mode swaps in rms quanta, already calibrated upstream
   assign app_stb_a = amp_hour_en ? q_stb[`LCEP_Q_CURRENT_RMS_VALUE]
                                  : q_stb[`LCEP_Q_APP];
   assign app_stb_b = amp_hour_en ? q_stb[`LCEP_Q_CURRENT_RMS_VALUE + 1]
                                  : q_stb[`LCEP_Q_APP + 1];
   assign app_neg_a = amp_hour_en ? q_neg[`LCEP_Q_CURRENT_RMS_VALUE]
                                  : q_neg[`LCEP_Q_APP];
   assign app_neg_b = amp_hour_en ? q_neg[`LCEP_Q_CURRENT_RMS_VALUE + 1]
                                  : q_neg[`LCEP_Q_APP + 1];

   // Clear-on-read strobes for the two result registers
   assign clr_a = reg_rd && (reg_addr == `LCEP_ADR_ENA)
      && mode_q[`LCEP_MODE_CLR];
   assign clr_b = reg_rd && (reg_addr == `LCEP_ADR_ENB)
      && mode_q[`LCEP_MODE_CLR];

   // Channel A result
   lcep_energy_acc u_acc_a (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .line_en(mode_q[`LCEP_MODE_LA]),
      .period_end(period_end),
      .rd_clear(clr_a),
      .q_stb(app_stb_a),
      .q_neg(app_neg_a),
      .energy(energy_a)
   );

   // Channel B result
   lcep_energy_acc u_acc_b (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .line_en(mode_q[`LCEP_MODE_LB]),
      .period_end(period_end),
      .rd_clear(clr_b),
      .q_stb(app_stb_b),
      .q_neg(app_neg_b),
      .energy(energy_b)
   );

   // ****************************************
   // Pulse source selection
   // ****************************************
   assign sel_one = cfg_q[`LCEP_CFG_SEL1 +: 4];
   assign sel_two = cfg_q[`LCEP_CFG_SEL2 +: 4];
   assign sum_one = half_total(half_one_q, q_stb);
   assign sum_two = half_total(half_two_q, q_stb);

   // Half-sum source keeps a one-bit residue between cycles
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         half_one_q <= 1'b0;
         half_two_q <= 1'b0;
      end else if (clk_en) begin
         half_one_q <= (sel_one == `LCEP_SRC_ACT_SUM) ? sum_one[0] : 1'b0;
         half_two_q <= (sel_two == `LCEP_SRC_ACT_SUM) ? sum_two[0] : 1'b0;
      end
   end

   // Converter pulse counts fed to each output divider
   assign inc_one = (sel_one == `LCEP_SRC_ACT_SUM)
      ? {1'b0, sum_one[1]}
      : src_count(sel_one, q_stb, amp_hour_en);
   assign inc_two = (sel_two == `LCEP_SRC_ACT_SUM)
      ? {1'b0, sum_two[1]}
      : src_count(sel_two, q_stb, amp_hour_en);

   // ****************************************
   // Pulse outputs
   // ****************************************

   // First output
   lcep_pulse_out #(
      .LOW_CYC(PULSE_LOW_CYC),
      .LIM_CYC(PULSE_LIM_CYC)
   ) u_pulse_one (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .out_en(!cfg_q[`LCEP_CFG_DIS1]),
      .divider(div_one_q),
      .inc(inc_one),
      .pulse_n(pulse_out_one_n)
   );

   // Second output
   lcep_pulse_out #(
      .LOW_CYC(PULSE_LOW_CYC),
      .LIM_CYC(PULSE_LIM_CYC)
   ) u_pulse_two (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .out_en(!cfg_q[`LCEP_CFG_DIS2]),
      .divider(div_two_q),
      .inc(inc_two),
      .pulse_n(pulse_out_two_n)
   );

   // ****************************************
   // Register reads
   // ****************************************

   // Read data registered one cycle after the read strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h00000000;
         rvalid_q <= 1'b0;
      end else if (clk_en) begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `LCEP_ADR_MODE: rdata_q <= {24'h000000, mode_q};
               `LCEP_ADR_HCYC: rdata_q <= {16'h0000, hcyc_q};
               `LCEP_ADR_DIV1: rdata_q <= {16'h0000, div_one_q};
               `LCEP_ADR_DIV2: rdata_q <= {16'h0000, div_two_q};
               `LCEP_ADR_CFG: rdata_q <= {16'h0000, cfg_q};
               `LCEP_ADR_ENA: rdata_q <= {{8{energy_a[23]}}, energy_a};
               `LCEP_ADR_ENB: rdata_q <= {{8{energy_b[23]}}, energy_b};
               `LCEP_ADR_IRQEN: begin
                  rdata_q <= 32'h00000000;
                  rdata_q[`LCEP_IRQ_DONE] <= irq_en_q;
               end
               `LCEP_ADR_IRQST: begin
                  rdata_q <= 32'h00000000;
                  rdata_q[`LCEP_IRQ_DONE] <= done_q;
               end
               default: rdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

endmodule : lcep_top

`default_nettype wire

// [shared/lcep_consts.svh]
// Constants for the line-cycle energy and pulse output block.
// Assumes a 10-bit register address space and a 25 MHz mclk.
`ifndef LCEP_CONSTS_SVH
`define LCEP_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LCEP_ADR_MODE 10'h004
`define LCEP_ADR_HCYC 10'h101
`define LCEP_ADR_DIV1 10'h103
`define LCEP_ADR_DIV2 10'h104
`define LCEP_ADR_CFG 10'h107
`define LCEP_ADR_ENA 10'h222
`define LCEP_ADR_ENB 10'h223
`define LCEP_ADR_IRQEN 10'h22C
`define LCEP_ADR_IRQST 10'h22D

// ****************************************
// Reset values and field positions
// ****************************************
`define LCEP_MODE_RST 8'h40
`define LCEP_MODE_LA 4
`define LCEP_MODE_LB 5
`define LCEP_MODE_CLR 6
`define LCEP_HCYC_RST 16'h0064
`define LCEP_DIV_RST 16'h0000
`define LCEP_CFG_RST 16'h0300
`define LCEP_CFG_SEL1 0
`define LCEP_CFG_SEL2 4
`define LCEP_CFG_DIS1 8
`define LCEP_CFG_DIS2 9
`define LCEP_IRQ_DONE 18

// ****************************************
// Pulse source codes
// ****************************************
`define LCEP_SRC_ACT_A 4'h0
`define LCEP_SRC_REACT_A 4'h1
`define LCEP_SRC_APP_A 4'h2
`define LCEP_SRC_CURRENT_RMS_VALUE_A 4'h3
`define LCEP_SRC_ACT_SUM 4'h4
`define LCEP_SRC_ACT_B 4'h5
`define LCEP_SRC_REACT_B 4'h6
`define LCEP_SRC_APP_B 4'h7
`define LCEP_SRC_CURRENT_RMS_VALUE_B 4'h8
`define LCEP_SRC_CURRENT_RMS_VALUE_SUM 4'h9

// ****************************************
// Quantum strobe indices and timing
// ****************************************
`define LCEP_Q_ACT 0
`define LCEP_Q_REACT 2
`define LCEP_Q_APP 4
`define LCEP_Q_CURRENT_RMS_VALUE 6
`define LCEP_CLK_HZ 25000000
`define LCEP_PULSE_LOW_MS 80
`define LCEP_PULSE_LIM_MS 160

`endif

// [shared/lcep_pkg.sv]
// Types for the line-cycle energy and pulse output block.
// Assumes lcep_consts.svh supplies the numeric values.
package lcep_pkg;

   // Pulse source select field
   typedef logic [3:0] lcep_src_t;

   // Line-cycle period engine states
   typedef enum logic {
      LCEP_IDLE,
      LCEP_RUN
   } lcep_period_t;

endpackage : lcep_pkg

// [verilog/lcep_energy_acc.sv]
// One channel of apparent energy accumulation with result register.
// Assumes quantum strobes and period ends come from mclk logic.
`timescale 1ns/1ps
`default_nettype none

module lcep_energy_acc (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Control
   input wire logic line_en,
   input wire logic period_end,
   input wire logic rd_clear,
   // Energy quanta
   input wire logic q_stb,
   input wire logic q_neg,
   // Result
   output logic [23:0] energy
);

   logic [23:0] run_q;
   logic [23:0] res_q;
   logic [23:0] delta;

   // Signed one-LSB step, wraps in 24 bits
   assign delta = q_stb ? (q_neg ? 24'hFFFFFF : 24'h000001) : 24'h000000;
   assign energy = res_q;

   // Running sum and result; a quantum on a clear cycle is kept
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         run_q <= 24'h000000;
         res_q <= 24'h000000;
      end else if (clk_en) begin
         if (!line_en) begin
            run_q <= 24'h000000;
            res_q <= (rd_clear ? 24'h000000 : res_q) + delta;
         end else if (period_end) begin
            run_q <= 24'h000000;
            res_q <= run_q + delta;
         end else begin
            run_q <= run_q + delta;
            if (rd_clear) begin
               res_q <= 24'h000000;
            end
         end
      end
   end

endmodule : lcep_energy_acc

`default_nettype wire

// [verilog/lcep_pulse_out.sv]
// Divider and pulse shaper for one calibration pulse output.
// Assumes inc counts converter pulses arriving this mclk cycle.
`timescale 1ns/1ps
`default_nettype none

module lcep_pulse_out #(
   parameter int unsigned LOW_CYC = 2000000,
   parameter int unsigned LIM_CYC = 4000000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Control
   input wire logic out_en,
   input wire logic [15:0] divider,
   input wire logic [1:0] inc,
   // Pin
   output logic pulse_n
);

   logic [15:0] div_cnt_q;
   logic [16:0] div_sum;
   logic [16:0] div_min;
   logic fire;
   logic [31:0] per_q;
   logic [31:0] low_q;
   logic [31:0] low_d;
   logic [31:0] width;
   logic out_n_q;

   // Zero divider acts as one, so every converter pulse passes
   assign div_min = (divider == 16'h0000) ? 17'h00001 : {1'b0, divider};
   assign div_sum = {1'b0, div_cnt_q} + {15'h0000, inc};
   assign fire = out_en && (div_sum >= div_min);

   // Fixed width after a long period, half period otherwise
   always_comb begin
      if (per_q > LIM_CYC) begin
         width = LOW_CYC;
      end else if (per_q[31:1] == 31'h00000000) begin
         width = 32'h00000001;
      end else begin
         width = {1'b0, per_q[31:1]};
      end
      if (fire) begin
         low_d = width;
      end else if (low_q != 32'h00000000) begin
         low_d = low_q - 32'h00000001;
      end else begin
         low_d = 32'h00000000;
      end
   end

   // Divider remainder
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_q <= 16'h0000;
      end else if (clk_en) begin
         if (!out_en) begin
            div_cnt_q <= 16'h0000;
         end else if (fire) begin
            div_cnt_q <= 16'(div_sum - div_min);
         end else begin
            div_cnt_q <= div_sum[15:0];
         end
      end
   end

   // Period measure, low time and the active-low pin
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         per_q <= 32'(LIM_CYC + 1);
         low_q <= 32'h00000000;
         out_n_q <= 1'b1;
      end else if (clk_en) begin
         if (!out_en) begin
            per_q <= 32'(LIM_CYC + 1);
            low_q <= 32'h00000000;
            out_n_q <= 1'b1;
         end else begin
            if (fire) begin
               per_q <= 32'h00000001;
            end else if (per_q <= LIM_CYC) begin
               per_q <= per_q + 32'h00000001;
            end
            low_q <= low_d;
            out_n_q <= (low_d == 32'h00000000);
         end
      end
   end

   assign pulse_n = out_n_q;

endmodule : lcep_pulse_out

`default_nettype wire

// [tb/lcep_top_props.sv]
// Port checker for the line-cycle energy and pulse output block.
// Assumes binding to lcep_top with clk_en high while checked.
`timescale 1ns/1ps
`default_nettype none
`include "lcep_consts.svh"

module lcep_top_props #(
   parameter int unsigned PULSE_LOW_CYC = 2000000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   // Events and pins
   input wire logic zx_stb,
   input wire logic [7:0] q_stb,
   input wire logic irq_n,
   input wire logic pulse_out_one_n,
   input wire logic pulse_out_two_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   logic [31:0] low1_q, low2_q;

   // Low-time counters for both pulse pins
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         low1_q <= 32'h0;
         low2_q <= 32'h0;
      end else begin
         low1_q <= pulse_out_one_n ? 32'h0 : low1_q + 32'h1;
         low2_q <= pulse_out_two_n ? 32'h0 : low2_q + 32'h1;
      end
   end

   property p_rd_answer;
      reg_rd && clk_en |=> reg_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
   property p_rdata_hold;
      !reg_rvalid |-> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without answer");
   property p_irq_fall;
      $fell(irq_n) |-> $past(zx_stb)
         || $past(reg_wr && reg_addr == `LCEP_ADR_IRQEN);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt without cause");
   property p_irq_rise;
      $rose(irq_n) |-> $past(reg_rd && reg_addr == `LCEP_ADR_IRQST)
         || $past(reg_wr && reg_addr == `LCEP_ADR_IRQEN);
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("done flag lost without read");
   property p_one_cause;
      $fell(pulse_out_one_n) |-> $past(|q_stb);
   endproperty
   a_one_cause: assert property (p_one_cause)
      else $error("pulse without quantum");
   property p_one_width;
      low1_q <= PULSE_LOW_CYC;
   endproperty
   a_one_width: assert property (p_one_width)
      else $error("pulse one too long");
   property p_two_width;
      low2_q <= PULSE_LOW_CYC;
   endproperty
   a_two_width: assert property (p_two_width)
      else $error("pulse two too long");
   property p_rst_quiet;
      $past(sys_rst) |-> irq_n && pulse_out_one_n && pulse_out_two_n;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("pins active after reset");
endmodule : lcep_top_props

bind lcep_top lcep_top_props #(.PULSE_LOW_CYC(PULSE_LOW_CYC)) u_props (
   .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .reg_rvalid, .zx_stb, .q_stb, .irq_n, .pulse_out_one_n, .pulse_out_two_n
);
`default_nettype wire

// [tb/lcep_cal_counter.sv]
// Calibration equipment model: counts pulses and times pulse one.
// Assumes active-low pins sampled on mclk.
`timescale 1ns/1ps
`default_nettype none

module lcep_cal_counter (
   // Clock and pins
   input wire logic mclk,
   input wire logic pin_one_n,
   input wire logic pin_two_n,
   // Results
   output int n_one,
   output int n_two,
   output int w_one
);
   int run = 0;
   logic p1 = 1'b1;
   logic p2 = 1'b1;

   // Falling edges count pulses, low cycles give width
   always @(posedge mclk) begin
      p1 <= pin_one_n;
      p2 <= pin_two_n;
      if (p1 && !pin_one_n)
         n_one <= n_one + 1;
      if (p2 && !pin_two_n)
         n_two <= n_two + 1;
      if (!pin_one_n)
         run <= run + 1;
      else if (!p1) begin
         w_one <= run;
         run <= 0;
      end
   end
   initial begin
      n_one = 0;
      n_two = 0;
      w_one = 0;
   end
endmodule : lcep_cal_counter
`default_nettype wire

// [tb/lcep_top_test.sv]
// Bench for the line-cycle energy and pulse output block.
// Assumes pulse width and period limit shortened to 20 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "lcep_consts.svh"

module lcep_top_test;
   logic mclk, sys_rst, clk_en, reg_wr, reg_rd, zx_stb, amp_hour_en;
   logic reg_rvalid, irq_n, p1_n, p2_n;
   logic [9:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0] q_stb, q_neg;
   logic [7:0] tab [10] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h03,
      8'h02, 8'h08, 8'h20, 8'h80, 8'h40};
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_one, n_two, w_one, k;

   lcep_top #(.PULSE_LOW_CYC(20), .PULSE_LIM_CYC(40)) u_lcep_top (
      .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_rvalid, .zx_stb, .q_stb, .q_neg, .amp_hour_en,
      .irq_n, .pulse_out_one_n(p1_n), .pulse_out_two_n(p2_n)
   );
   lcep_cal_counter u_lcep_cal_counter (
      .mclk, .pin_one_n(p1_n), .pin_two_n(p2_n), .n_one, .n_two, .w_one
   );

   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask : w
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rc(input logic [9:0] a, input logic [31:0] e);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask : rc
   task automatic ev(input logic z, input logic [7:0] s);
      @(negedge mclk);
      zx_stb = z;
      q_stb = s;
      @(negedge mclk);
      zx_stb = 1'b0;
      q_stb = 8'h00;
   endtask : ev

   task automatic t_reset;
      rc(`LCEP_ADR_MODE, 32'h40);
      rc(`LCEP_ADR_CFG, 32'h300);
      rc(10'h3FF, 32'h0);
      chk(p1_n & p2_n & irq_n, 32'h1);
   endtask : t_reset
   task automatic t_free;
      wr(`LCEP_ADR_MODE, 32'h0);
      q_neg = 8'h10;
      ev(1'b0, 8'h10);
      q_neg = 8'h00;
      rc(`LCEP_ADR_ENA, 32'hFFFFFFFF);
      rc(`LCEP_ADR_ENA, 32'hFFFFFFFF);
      amp_hour_en = 1'b1;
      ev(1'b0, 8'h40);
      amp_hour_en = 1'b0;
      rc(`LCEP_ADR_ENA, 32'h0);
   endtask : t_free
   task automatic t_line;
      wr(`LCEP_ADR_HCYC, 32'h2);
      wr(`LCEP_ADR_IRQEN, 32'h40000);
      wr(`LCEP_ADR_MODE, 32'h70);
      // Quanta follow the enable, so the first result is exact
      ev(1'b0, 8'h10);
      ev(1'b0, 8'h30);
      ev(1'b1, 8'h00);
      w(2);
      chk(irq_n, 32'h1);
      ev(1'b1, 8'h00);
      w(2);
      chk(irq_n, 32'h0);
      rc(`LCEP_ADR_IRQST, 32'h40000);
      rc(`LCEP_ADR_ENA, 32'h2);
      rc(`LCEP_ADR_ENB, 32'h1);
      rc(`LCEP_ADR_ENA, 32'h0);
      wr(`LCEP_ADR_HCYC, 32'h3);
      ev(1'b0, 8'h10);
      rc(`LCEP_ADR_ENA, 32'h0);
      ev(1'b1, 8'h00);
      ev(1'b1, 8'h00);
      w(2);
      chk(irq_n, 32'h0);
      rc(`LCEP_ADR_IRQST, 32'h40000);
      rc(`LCEP_ADR_ENA, 32'h1);
      ev(1'b1, 8'h00);
      ev(1'b1, 8'h00);
      w(2);
      chk(irq_n, 32'h1);
      ev(1'b1, 8'h00);
      w(2);
      chk(irq_n, 32'h0);
      rc(`LCEP_ADR_IRQST, 32'h40000);
      wr(`LCEP_ADR_MODE, 32'h0);
   endtask : t_line
   task automatic t_pulse;
      wr(`LCEP_ADR_DIV1, 32'h2);
      wr(`LCEP_ADR_CFG, 32'h40);
      ev(1'b0, 8'h01);
      w(25);
      chk(n_one, 0);
      ev(1'b0, 8'h01);
      w(25);
      chk(n_one, 1);
      chk(w_one, 20);
      ev(1'b0, 8'h03);
      w(25);
      ev(1'b0, 8'h01);
      w(25);
      chk(n_two, 2);
      chk(n_one, 2);
      wr(`LCEP_ADR_DIV1, 32'h0);
      ev(1'b0, 8'h01);
      w(29);
      ev(1'b0, 8'h01);
      w(29);
      chk(w_one, 15);
      for (int i = 0; i < 10; i++) begin
         wr(`LCEP_ADR_CFG, i);
         k = n_one;
         ev(1'b0, tab[i]);
         w(25);
         chk(n_one, k + 1);
      end
      amp_hour_en = 1'b1;
      wr(`LCEP_ADR_CFG, 32'h2);
      ev(1'b0, 8'h40);
      w(25);
      chk(n_one, k + 2);
      amp_hour_en = 1'b0;
      wr(`LCEP_ADR_CFG, 32'h300);
      ev(1'b0, 8'h01);
      w(25);
      chk(n_one, k + 2);
   endtask : t_pulse

   // Reset, then the scenarios in turn
   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_addr = 10'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0;
      zx_stb = 1'b0;
      q_stb = 8'h00;
      q_neg = 8'h00;
      amp_hour_en = 1'b0;
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      t_reset();
      t_free();
      t_line();
      t_pulse();
      wrap_up();
   end
endmodule : lcep_top_test
`default_nettype wire
